/* File: core/bms_params.svh */
// Purpose: Constants of the boot mode select block
// Assumes: Included by the package and the top module only
// Notes:   Register offsets are word indexes; byte address is index * 4
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH

`define BMS_ADDR_W          20
`define BMS_IDX_STATUS      18'h0FE0A
`define BMS_IDX_CONTROL     18'h0FE0B
`define BMS_IDX_INFO        18'h0FE0C
`define BMS_ALT_FLAG_BIT    5
`define BMS_CTL_SWRST_BIT   0
`define BMS_INFO_DONE_BIT   3
`define BMS_INFO_WSER_BIT   4
`define BMS_INFO_WCAN_BIT   5
`define BMS_INFO_SSER_BIT   6
`define BMS_INFO_SCAN_BIT   7
`define BMS_INFO_STRAP_LSB  8
`define BMS_INFO_SEL_LSB    16
`define BMS_STRAP_NORMAL    2'h3
`define BMS_STRAP_STD       2'h2
`define BMS_STRAP_ALT       2'h1
`define BMS_FA_USER_OP0     24'h000000
`define BMS_FA_USER_OP1     24'h001FFC
`define BMS_FA_USER_REF     24'h001FFE
`define BMS_FA_ALT_OP0      24'h090000
`define BMS_FA_ALT_OP1      24'h091FFC
`define BMS_FA_ALT_REF      24'h091FFE
`define BMS_SEL_ALL_ZERO    16'h0000
`define BMS_SEL_ALL_ONE     16'hFFFF
`define BMS_SEL_BOTH        8'h03
`define BMS_SEL_SERIAL      8'h01
`define BMS_SEL_CAN         8'h02
`define BMS_SEL_SERIAL_BIT  0
`define BMS_SEL_CAN_BIT     1
`define BMS_RESP_OKAY       2'h0
`define BMS_RESP_SLVERR     2'h2

`endif

/* File: core/bms_pkg.sv */
// Purpose: Types of the boot mode select block
// Assumes: Constants come from bms_params.svh
// Notes:   Bus carriers are packed structs
`include "bms_params.svh"

package bms_pkg;

   typedef struct packed {
      logic                   awvalid;
      logic [`BMS_ADDR_W-1:0] awaddr;
      logic                   wvalid;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   bready;
      logic                   arvalid;
      logic [`BMS_ADDR_W-1:0] araddr;
      logic                   rready;
   } bms_axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } bms_axil_rsp_t;

   typedef enum logic [2:0] {
      BMS_PATH_NONE       = 3'h0,
      BMS_PATH_NORMAL     = 3'h1,
      BMS_PATH_STD_LOADER = 3'h2,
      BMS_PATH_USER_VEC   = 3'h3,
      BMS_PATH_ALT_START  = 3'h4,
      BMS_PATH_SELECTIVE  = 3'h5,
      BMS_PATH_TEST_LOOP  = 3'h6,
      BMS_PATH_TEST_MODE  = 3'h7
   } bms_path_t;

   typedef struct packed {
      bms_path_t path;
      logic      done;
      logic      watch_serial;
      logic      watch_can;
   } bms_outcome_t;

   typedef struct packed {
      logic        req;
      logic [23:0] addr;
   } bms_flash_req_t;

   typedef enum logic [1:0] {
      BMS_CHK_USER = 2'h0,
      BMS_CHK_ALT  = 2'h1,
      BMS_CHK_SEL  = 2'h2
   } bms_chk_t;

   typedef enum logic [4:0] {
      BMS_ST_HOLD   = 5'b00001,
      BMS_ST_DECODE = 5'b00010,
      BMS_ST_FETCH  = 5'b00100,
      BMS_ST_EVAL   = 5'b01000,
      BMS_ST_DONE   = 5'b10000
   } bms_state_t;

endpackage

/* File: core/bms_boot_mode_select.sv */
// Purpose: Boot configuration latch, boot path decode, signature checks
//          and selective boot channel choice, with an AXI4-Lite slave
// Assumes: One clock; pins pass a three-stage filter; flash answers
//          each request with a one-cycle valid pulse
// Notes:
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "bms_params.svh"
`timescale 1ns/1ps
`default_nettype none

module bms_boot_mode_select (
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire bms_pkg::bms_axil_req_t  axil_req,
   output var  bms_pkg::bms_axil_rsp_t  axil_rsp,
   input  wire logic                    reset_input_pin,
   input  wire logic [1:0]              port0_low_strap,
   input  wire logic                    serial0_receive_line,
   input  wire logic                    can_one_receive_line,
   input  wire logic [15:0]             flash_rd_data,
   input  wire logic                    flash_rd_valid,
   output var  bms_pkg::bms_flash_req_t flash_req,
   output var  bms_pkg::bms_outcome_t   outcome,
   output logic                         alternate_boot_flag,
   output logic [1:0]                   start_seen
);
   import bms_pkg::*;

   // Signature arithmetic, used for both signature sets
   function automatic logic sig_ok(input logic [15:0] op0,
                                   input logic [15:0] op1,
                                   input logic [15:0] refw);
      logic [15:0] sum;
      sum = op0 + op1;
      return ({sum[15:8], ~sum[7:0]} == refw);
   endfunction

   // Flash address of each word of each check
   function automatic logic [23:0] fetch_addr(input bms_chk_t ph,
                                              input logic [1:0] idx);
      logic [23:0] a;
      a = `BMS_FA_USER_OP1;
      if (ph == BMS_CHK_USER) begin
         a = (idx == 2'h0) ? `BMS_FA_USER_OP0 :
             (idx == 2'h1) ? `BMS_FA_USER_OP1 : `BMS_FA_USER_REF;
      end else if (ph == BMS_CHK_ALT) begin
         a = (idx == 2'h0) ? `BMS_FA_ALT_OP0 :
             (idx == 2'h1) ? `BMS_FA_ALT_OP1 : `BMS_FA_ALT_REF;
      end
      return a;
   endfunction

   // Word-aligned register index, or all ones when misaligned
   function automatic logic [17:0] reg_idx(input logic [19:0] a);
      return (a[1:0] == 2'h0) ? a[19:2] : 18'h3FFFF;
   endfunction

   // Pin filter: pins = {can rx, serial rx, strap[1:0], reset pin}
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   logic [4:0] pin_s3_r;
   logic [4:0] pin_f_r;
   logic [4:0] pin_f_q_r;
   logic [4:0] pin_f_nxt;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_r <= 5'h1F;
         pin_s2_r <= 5'h1F;
         pin_s3_r <= 5'h1F;
      end else begin
         pin_s1_r <= {can_one_receive_line, serial0_receive_line,
                      port0_low_strap, reset_input_pin};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // A change counts only once stages two and three agree
   assign pin_f_nxt = (pin_s2_r & pin_s3_r) |
                      (pin_f_r & (pin_s2_r | pin_s3_r));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // Start high like the sync stages: no false edge after reset
         pin_f_r   <= 5'h1F;
         pin_f_q_r <= 5'h1F;
      end else begin
         pin_f_r   <= pin_f_nxt;
         pin_f_q_r <= pin_f_r;
      end
   end

   logic pin_rise;
   logic pin_low;
   logic ser_fall;
   logic can_fall;
   assign pin_rise = pin_f_r[0] & ~pin_f_q_r[0];
   assign pin_low  = ~pin_f_r[0];
   assign ser_fall = ~pin_f_r[3] & pin_f_q_r[3];
   assign can_fall = ~pin_f_r[4] & pin_f_q_r[4];

   // AXI4-Lite write side
   logic        aw_hold_r;
   logic [19:0] awaddr_r;
   logic        w_hold_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_fire;
   logic        sw_reset_r;

   assign wr_fire = aw_hold_r & w_hold_r & ~axil_rsp.bvalid;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_hold_r <= 1'b0;
         awaddr_r  <= 20'h00000;
         w_hold_r  <= 1'b0;
         wdata_r   <= 32'h00000000;
         wstrb_r   <= 4'h0;
      end else begin
         if (axil_req.awvalid && axil_rsp.awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= axil_req.awaddr;
         end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
         end
         if (axil_req.wvalid && axil_rsp.wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= axil_req.wdata;
            wstrb_r  <= axil_req.wstrb;
         end else if (wr_fire) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // Only the control register takes writes; read-only ones ignore them
   logic wr_mapped;
   assign wr_mapped = (reg_idx(awaddr_r) == `BMS_IDX_STATUS) ||
                      (reg_idx(awaddr_r) == `BMS_IDX_CONTROL) ||
                      (reg_idx(awaddr_r) == `BMS_IDX_INFO);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         axil_rsp.awready <= 1'b0;
         axil_rsp.wready  <= 1'b0;
         axil_rsp.bvalid  <= 1'b0;
         axil_rsp.bresp   <= `BMS_RESP_OKAY;
         sw_reset_r       <= 1'b0;
      end else begin
         axil_rsp.awready <= ~aw_hold_r & ~(axil_req.awvalid &
                             axil_rsp.awready) & ~axil_rsp.bvalid;
         axil_rsp.wready  <= ~w_hold_r & ~(axil_req.wvalid &
                             axil_rsp.wready) & ~axil_rsp.bvalid;
         sw_reset_r       <= wr_fire && wstrb_r[0] &&
                             wdata_r[`BMS_CTL_SWRST_BIT] &&
                             (reg_idx(awaddr_r) == `BMS_IDX_CONTROL);
         if (wr_fire) begin
            axil_rsp.bvalid <= 1'b1;
            axil_rsp.bresp  <= wr_mapped ? `BMS_RESP_OKAY
                                         : `BMS_RESP_SLVERR;
         end else if (axil_req.bready) begin
            axil_rsp.bvalid <= 1'b0;
         end
      end
   end

   // Boot sequencer
   bms_state_t   state_r;
   bms_chk_t     phase_r;
   logic [1:0]   widx_r;
   logic [15:0]  word_r [3];
   logic [1:0]   strap_r;
   logic         flag_r;
   logic [1:0]   seen_r;
   logic [15:0]  sel_word;
   logic         hold_rst;

   assign sel_word = word_r[1];
   assign hold_rst = pin_low | sw_reset_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r   <= BMS_ST_HOLD;
         phase_r   <= BMS_CHK_USER;
         widx_r    <= 2'h0;
         strap_r   <= 2'h0;
         flash_req <= '0;
         outcome   <= '0;
         word_r[0] <= 16'h0000;
         word_r[1] <= 16'h0000;
         word_r[2] <= 16'h0000;
      end else if (pin_low) begin
         // Pin held low acts as hardware reset
         state_r   <= BMS_ST_HOLD;
         flash_req <= '0;
         outcome   <= '0;
      end else if (sw_reset_r) begin
         // Software reset reruns boot from the strap already caught
         state_r   <= BMS_ST_DECODE;
         flash_req <= '0;
         outcome   <= '0;
      end else begin
         case (state_r)
            BMS_ST_HOLD: begin
               if (pin_rise) begin
                  strap_r <= pin_f_r[2:1];
                  state_r <= BMS_ST_DECODE;
               end
            end
            BMS_ST_DECODE: begin
               phase_r <= BMS_CHK_USER;
               widx_r  <= 2'h0;
               case (strap_r)
                  `BMS_STRAP_NORMAL: begin
                     outcome.path <= BMS_PATH_NORMAL;
                     outcome.done <= 1'b1;
                     state_r      <= BMS_ST_DONE;
                  end
                  `BMS_STRAP_STD: begin
                     outcome.path <= BMS_PATH_STD_LOADER;
                     outcome.done <= 1'b1;
                     state_r      <= BMS_ST_DONE;
                  end
                  `BMS_STRAP_ALT: begin
                     // User signature goes first
                     flash_req.req  <= 1'b1;
                     flash_req.addr <= fetch_addr(BMS_CHK_USER, 2'h0);
                     state_r        <= BMS_ST_FETCH;
                  end
                  default: begin
                     outcome.path <= BMS_PATH_TEST_MODE;
                     outcome.done <= 1'b1;
                     state_r      <= BMS_ST_DONE;
                  end
               endcase
            end
            BMS_ST_FETCH: begin
               if (flash_rd_valid) begin
                  word_r[widx_r] <= flash_rd_data;
                  if (phase_r == BMS_CHK_SEL || widx_r == 2'h2) begin
                     flash_req.req <= 1'b0;
                     state_r       <= BMS_ST_EVAL;
                  end else begin
                     widx_r         <= widx_r + 2'h1;
                     flash_req.addr <= fetch_addr(phase_r,
                                                  widx_r + 2'h1);
                  end
               end
            end
            BMS_ST_EVAL: begin
               case (phase_r)
                  BMS_CHK_USER: begin
                     if (sig_ok(word_r[0], word_r[1], word_r[2])) begin
                        outcome.path <= BMS_PATH_USER_VEC;
                        outcome.done <= 1'b1;
                        state_r      <= BMS_ST_DONE;
                     end else begin
                        phase_r        <= BMS_CHK_ALT;
                        widx_r         <= 2'h0;
                        flash_req.req  <= 1'b1;
                        flash_req.addr <= fetch_addr(BMS_CHK_ALT, 2'h0);
                        state_r        <= BMS_ST_FETCH;
                     end
                  end
                  BMS_CHK_ALT: begin
                     if (sig_ok(word_r[0], word_r[1], word_r[2])) begin
                        outcome.path <= BMS_PATH_ALT_START;
                        outcome.done <= 1'b1;
                        state_r      <= BMS_ST_DONE;
                     end else begin
                        // Re-read lands in slot one
                        phase_r        <= BMS_CHK_SEL;
                        widx_r         <= 2'h1;
                        flash_req.req  <= 1'b1;
                        flash_req.addr <= fetch_addr(BMS_CHK_SEL, 2'h1);
                        state_r        <= BMS_ST_FETCH;
                     end
                  end
                  default: begin
                     outcome.done <= 1'b1;
                     state_r      <= BMS_ST_DONE;
                     if (sel_word == `BMS_SEL_ALL_ZERO ||
                         sel_word == `BMS_SEL_ALL_ONE) begin
                        outcome.path <= BMS_PATH_STD_LOADER;
                     end else begin
                        // High byte plays no part
                        case (sel_word[7:0])
                           `BMS_SEL_BOTH, `BMS_SEL_SERIAL,
                           `BMS_SEL_CAN: begin
                              outcome.path <= BMS_PATH_SELECTIVE;
                              outcome.watch_serial <=
                                 sel_word[`BMS_SEL_SERIAL_BIT];
                              outcome.watch_can <=
                                 sel_word[`BMS_SEL_CAN_BIT];
                           end
                           // Nonzero reserved bits land here
                           default: outcome.path <= BMS_PATH_TEST_LOOP;
                        endcase
                     end
                  end
               endcase
            end
            BMS_ST_DONE: begin
               state_r <= BMS_ST_DONE;
            end
            default: begin
               state_r <= BMS_ST_HOLD;
            end
         endcase
      end
   end

   // Alternate flag: set by strap 01 at capture only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag_r <= 1'b0;
      end else if (state_r == BMS_ST_HOLD && pin_rise) begin
         flag_r <= (pin_f_r[2:1] == `BMS_STRAP_ALT);
      end else if (hold_rst) begin
         flag_r <= 1'b0;
      end
   end

   // Start conditions on watched lines; sticky, event beats software reset, pin low beats event
   logic [1:0] seen_set;
   assign seen_set[0] = outcome.watch_serial & ser_fall;
   assign seen_set[1] = outcome.watch_can & can_fall;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seen_r <= 2'h0;
      end else begin
         seen_r <= (seen_r & {2{~hold_rst}}) | (seen_set & {2{~pin_low}});
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         alternate_boot_flag <= 1'b0;
         start_seen          <= 2'h0;
      end else begin
         alternate_boot_flag <= flag_r;
         start_seen          <= seen_r;
      end
   end

   // AXI4-Lite read side
   logic [31:0] rd_word;
   logic        rd_hit;
   always_comb begin
      rd_word = 32'h00000000;
      rd_hit  = 1'b1;
      case (reg_idx(axil_req.araddr))
         `BMS_IDX_STATUS: rd_word[`BMS_ALT_FLAG_BIT] = flag_r;
         `BMS_IDX_CONTROL: rd_word = 32'h00000000;
         `BMS_IDX_INFO: begin
            rd_word[2:0] = outcome.path;
            rd_word[`BMS_INFO_DONE_BIT] = outcome.done;
            rd_word[`BMS_INFO_WSER_BIT] = outcome.watch_serial;
            rd_word[`BMS_INFO_WCAN_BIT] = outcome.watch_can;
            rd_word[`BMS_INFO_SSER_BIT] = seen_r[0];
            rd_word[`BMS_INFO_SCAN_BIT] = seen_r[1];
            rd_word[`BMS_INFO_STRAP_LSB+:2] = strap_r;
            rd_word[`BMS_INFO_SEL_LSB+:16] = sel_word;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         axil_rsp.arready <= 1'b0;
         axil_rsp.rvalid  <= 1'b0;
         axil_rsp.rdata   <= 32'h00000000;
         axil_rsp.rresp   <= `BMS_RESP_OKAY;
      end else begin
         axil_rsp.arready <= ~axil_rsp.rvalid & ~(axil_req.arvalid &
                             axil_rsp.arready);
         if (axil_req.arvalid && axil_rsp.arready) begin
            axil_rsp.rvalid <= 1'b1;
            axil_rsp.rdata  <= rd_word;
            axil_rsp.rresp  <= rd_hit ? `BMS_RESP_OKAY
                                      : `BMS_RESP_SLVERR;
         end else if (axil_req.rready) begin
            axil_rsp.rvalid <= 1'b0;
         end
      end
   end

endmodule // bms_boot_mode_select

`default_nettype wire

/* File: verif/bms_flash_model.sv */
// Purpose: Flash partner answering the boot signature reads
// Assumes: Six words at the user and alternate signature addresses
// Notes:   Latency set by lat; data toggles while not valid
`timescale 1ns/1ps
`default_nettype none

module bms_flash_model (
   input  wire logic                    clk,
   input  wire bms_pkg::bms_flash_req_t flash_req,
   input  wire logic [15:0]             words [6],
   input  wire logic [3:0]              lat,
   output logic [15:0]                  flash_rd_data,
   output logic                         flash_rd_valid
);
   import bms_pkg::*;
   logic [3:0] cnt_r;
   logic [2:0] idx;

   initial begin
      cnt_r = 4'h0;
      flash_rd_valid = 1'b0;
      flash_rd_data = 16'h0000;
   end

   always_comb begin
      case (flash_req.addr)
         24'h000000: idx = 3'h0;
         24'h001FFC: idx = 3'h1;
         24'h001FFE: idx = 3'h2;
         24'h090000: idx = 3'h3;
         24'h091FFC: idx = 3'h4;
         24'h091FFE: idx = 3'h5;
         default:    idx = 3'h7;
      endcase
   end

   // Released data flips each cycle, so it shows the last word every other cycle
   always @(posedge clk) begin
      flash_rd_valid <= 1'b0;
      flash_rd_data <= ~flash_rd_data;
      if (!flash_req.req || flash_rd_valid) begin
         cnt_r <= 4'h0;
      end else if (cnt_r == lat) begin
         flash_rd_valid <= 1'b1;
         flash_rd_data <= (idx < 3'h6) ? words[idx] : ~flash_rd_data;
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule // bms_flash_model

`default_nettype wire

/* File: verif/bms_assertions.sv */
// Purpose: Port checks of the boot mode select block
// Assumes: One clock domain, reset rstn
// Notes:   Flash latency is free, so order checks key on valid
`timescale 1ns/1ps
`default_nettype none

module bms_checker (
   input wire logic                    clk,
   input wire logic                    rstn,
   input wire bms_pkg::bms_axil_req_t  axil_req,
   input wire bms_pkg::bms_axil_rsp_t  axil_rsp,
   input wire logic                    reset_input_pin,
   input wire logic [1:0]              port0_low_strap,
   input wire logic                    serial0_receive_line,
   input wire logic                    can_one_receive_line,
   input wire logic [15:0]             flash_rd_data,
   input wire logic                    flash_rd_valid,
   input wire bms_pkg::bms_flash_req_t flash_req,
   input wire bms_pkg::bms_outcome_t   outcome,
   input wire logic                    alternate_boot_flag,
   input wire logic [1:0]              start_seen
);
   import bms_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_back(logic [23:0] a);
      flash_rd_valid && flash_req.req && flash_req.addr == a;
   endsequence
   sequence s_next(logic [23:0] a);
      flash_req.req && flash_req.addr == a;
   endsequence
   // Flag must not drop while nothing resets it
   sequence s_quiet;
      alternate_boot_flag && reset_input_pin && !axil_req.wvalid;
   endsequence

   a_done_path: assert property ($rose(outcome.done) |-> outcome.path != 0)
      else $error("done without a boot path");
   a_plain_noflag: assert property (outcome.done && outcome.path inside
      {BMS_PATH_NORMAL, BMS_PATH_TEST_MODE} |-> !alternate_boot_flag)
      else $error("flag set on a non alternate path");
   a_flag_path: assert property (alternate_boot_flag && outcome.done |->
      outcome.path inside {[3'h2:3'h6]})
      else $error("flag set with wrong path");
   a_sel_watch: assert property (outcome.done && outcome.path ==
      BMS_PATH_SELECTIVE |-> outcome.watch_serial || outcome.watch_can)
      else $error("selective path watches nothing");
   a_no_watch: assert property (outcome.done && outcome.path !=
      BMS_PATH_SELECTIVE |-> !outcome.watch_serial && !outcome.watch_can)
      else $error("watch bit outside selective path");
   a_serial_cause: assert property ($rose(start_seen[0]) |-> outcome.watch_serial)
      else $error("serial start seen while unwatched");
   a_can_cause: assert property ($rose(start_seen[1]) |-> outcome.watch_can)
      else $error("can start seen while unwatched");
   a_user_order: assert property (s_back(24'h000000) |=> s_next(24'h001FFC))
      else $error("user operand order broken");
   a_alt_order: assert property (s_back(24'h090000) |=> s_next(24'h091FFC))
      else $error("alternate operand order broken");
   a_flag_holds: assert property (s_quiet [*6] |=> alternate_boot_flag)
      else $error("flag dropped without reset");
endmodule // bms_checker

bind bms_boot_mode_select bms_checker i_bms_checker (.clk, .rstn, .axil_req,
   .axil_rsp, .reset_input_pin, .port0_low_strap, .serial0_receive_line,
   .can_one_receive_line, .flash_rd_data, .flash_rd_valid, .flash_req,
   .outcome, .alternate_boot_flag, .start_seen);

`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Self-checking bench of the boot mode select block
// Assumes: Flash partner answers every request
// Notes:   Expectations come from strap and flash word tables
`timescale 1ns/1ps
`default_nettype none

module tb;
   import bms_pkg::*;
   logic           clk = 1'b0;
   logic           rstn = 1'b0;
   bms_axil_req_t  axil_req = '0;
   bms_axil_rsp_t  axil_rsp;
   logic           reset_input_pin = 1'b0;
   logic [1:0]     port0_low_strap = 2'h3;
   logic           serial0_receive_line = 1'b1;
   logic           can_one_receive_line = 1'b1;
   logic [15:0]    flash_rd_data;
   logic           flash_rd_valid;
   bms_flash_req_t flash_req;
   bms_outcome_t   outcome;
   logic           alternate_boot_flag;
   logic [1:0]     start_seen;
   logic [15:0]    words [6];
   logic [3:0]     lat = 4'h0;
   logic [31:0]    rd;
   logic [1:0]     rr;
   int             errors = 0;
   int             samples_checked = 0;
   localparam logic [15:0] sel_word [7] = '{16'h0000, 16'hFFFF, 16'h5503,
      16'hAA01, 16'h0002, 16'h0007, 16'h0100};
   localparam logic [2:0] sel_path [7] = '{2, 2, 5, 5, 5, 6, 6};
   localparam logic [1:0] sel_watch [7] = '{0, 0, 3, 1, 2, 0, 0};

   bms_boot_mode_select i_bms_boot_mode_select (.clk, .rstn, .axil_req,
      .axil_rsp, .reset_input_pin, .port0_low_strap, .serial0_receive_line,
      .can_one_receive_line, .flash_rd_data, .flash_rd_valid, .flash_req,
      .outcome, .alternate_boot_flag, .start_seen);
   bms_flash_model i_bms_flash_model (.clk, .flash_req, .words, .lat,
      .flash_rd_data, .flash_rd_valid);

   always #2 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] sig(input logic [15:0] a, b);
      logic [15:0] s;
      s = a + b;
      return {s[15:8], ~s[7:0]};
   endfunction

   task automatic setw(input logic [15:0] u1, input logic uok, aok);
      words[0] = 16'h1234;
      words[1] = u1;
      words[2] = sig(16'h1234, u1) ^ {15'h0, ~uok};
      words[3] = 16'hA5A5;
      words[4] = 16'h0F0F;
      words[5] = sig(16'hA5A5, 16'h0F0F) ^ {15'h0, ~aok};
   endtask

   // Strap held steady well around the pin edge
   task automatic boot(input logic [1:0] s);
      int n;
      @(posedge clk);
      port0_low_strap <= s;
      reset_input_pin <= 1'b0;
      repeat (8) @(posedge clk);
      reset_input_pin <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (outcome.done !== 1'b1 && n < 300);
      if (n >= 300) errors++;
      repeat (4) @(posedge clk);
   endtask

   task automatic boot_is(input logic [1:0] s, input logic [2:0] p,
                          input logic f, input logic [1:0] w);
      boot(s);
      chk({29'h0, outcome.path}, {29'h0, p});
      chk({31'h0, alternate_boot_flag}, {31'h0, f});
      chk({30'h0, outcome.watch_can, outcome.watch_serial}, {30'h0, w});
   endtask

   task automatic axw(input logic [19:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      axil_req.awvalid <= 1'b1;
      axil_req.awaddr <= a;
      axil_req.wvalid <= 1'b1;
      axil_req.wdata <= d;
      axil_req.wstrb <= 4'hF;
      axil_req.bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (axil_rsp.awready) axil_req.awvalid <= 1'b0;
         if (axil_rsp.wready) axil_req.wvalid <= 1'b0;
      end while (axil_rsp.bvalid !== 1'b1 && n < 100);
      if (n >= 100) errors++;
      axil_req.bready <= 1'b0;
   endtask

   task automatic axr(input logic [19:0] a);
      int n;
      @(posedge clk);
      axil_req.arvalid <= 1'b1;
      axil_req.araddr <= a;
      axil_req.rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (axil_rsp.arready) axil_req.arvalid <= 1'b0;
      end while (axil_rsp.rvalid !== 1'b1 && n < 100);
      if (n >= 100) errors++;
      rd = axil_rsp.rdata;
      rr = axil_rsp.rresp;
      axil_req.rready <= 1'b0;
   endtask

   task automatic t_sig;
      lat <= 4'h3;
      setw(16'h0101, 1'b1, 1'b1);
      boot_is(2'h1, BMS_PATH_USER_VEC, 1'b1, 2'h0);
      setw(16'h0101, 1'b0, 1'b1);
      boot_is(2'h1, BMS_PATH_ALT_START, 1'b1, 2'h0);
      lat <= 4'h0;
      $display("signature test done");
   endtask

   task automatic t_straps;
      boot_is(2'h2, BMS_PATH_STD_LOADER, 1'b0, 2'h0);
      boot_is(2'h3, BMS_PATH_NORMAL, 1'b0, 2'h0);
      boot_is(2'h0, BMS_PATH_TEST_MODE, 1'b0, 2'h0);
      $display("strap test done");
   endtask

   task automatic t_sel;
      for (int i = 0; i < 7; i++) begin
         setw(sel_word[i], 1'b0, 1'b0);
         boot_is(2'h1, sel_path[i], 1'b1, sel_watch[i]);
      end
      $display("selective test done");
   endtask

   task automatic t_start;
      for (int i = 1; i < 3; i++) begin
         setw(16'(i), 1'b0, 1'b0);
         boot(2'h1);
         serial0_receive_line <= 1'b0;
         can_one_receive_line <= 1'b0;
         repeat (12) @(posedge clk);
         chk({30'h0, start_seen}, 32'(i));
         serial0_receive_line <= 1'b1;
         can_one_receive_line <= 1'b1;
      end
      $display("start watch test done");
   endtask

   task automatic t_regs;
      setw(16'h0101, 1'b1, 1'b1);
      boot(2'h1);
      axr(20'h3F828);
      chk(rd & 32'h20, 32'h20);
      axw(20'h3F828, 32'h0);
      axr(20'h3F828);
      chk(rd & 32'h20, 32'h20);
      axr(20'h00100);
      chk({30'h0, rr}, 32'h2);
      axw(20'h3F82C, 32'h1);
      axr(20'h3F828);
      chk(rd & 32'h20, 32'h0);
      chk({31'h0, alternate_boot_flag}, 32'h0);
      $display("register test done");
   endtask

   task automatic finish_test;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Whole run needs under a thousand cycles
   initial begin
      #80000;
      errors++;
      finish_test;
   end

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      t_sig;
      t_straps;
      t_sel;
      t_start;
      t_regs;
      finish_test;
   end
endmodule // tb

`default_nettype wire
